//--- design/erhm_defs.vh
// Shared constants for the error history unit: widths, tag codes,
// reset values. Definitions only; included by both design files.
`ifndef ERHM_DEFS_VH
`define ERHM_DEFS_VH

// Monitored address bits (chip-level resolution) and syndrome width
`define ERHM_AW         8
`define ERHM_SW         8
// Stack depth and its index width
`define ERHM_DEPTH      16
`define ERHM_IW         4

// Tag encodings of a stack word
`define ERHM_TAG_SOFT   2'h0
`define ERHM_TAG_FIRM   2'h1
`define ERHM_TAG_HARD   2'h2
`define ERHM_TAG_TWOH   2'h3

// Reset values
`define ERHM_SYN_RST    8'h00
`define ERHM_AD_RST     8'h00
`define ERHM_IDX_RST    4'h0
`define ERHM_VLD_RST    16'h0000

`endif

//--- design/erhm_match.v
// Address comparator for the error history stack.
// Assumes packed address words from the owner of the stack, same clock.
`timescale 1ns/10ps
`include "erhm_defs.vh"

module erhm_match (
    input  wire [`ERHM_DEPTH-1:0]             valid,
    input  wire [`ERHM_DEPTH*`ERHM_AW-1:0]    addr_flat,
    input  wire [`ERHM_AW-1:0]                key,
    output reg                                hit,
    output reg  [`ERHM_IW-1:0]                idx
);

    integer i;

    // Scan from the top so the lowest matching word wins; only one reported
    always @* begin
        hit = 1'b0;
        idx = `ERHM_IDX_RST;
        for (i = `ERHM_DEPTH - 1; i >= 0; i = i - 1) begin
            if (valid[i] && addr_flat[i*`ERHM_AW +: `ERHM_AW] == key) begin
                hit = 1'b1;
                idx = i[`ERHM_IW-1:0];
            end
        end
    end

endmodule // erhm_match

//--- design/erhm_unit.v
// Error history unit: logs error addresses with syndrome and tag, and
// steers the corrector through injection or double complement cycles.
// Assumes the corrector and software run on sys_clk; no synchronisers.
`timescale 1ns/10ps
`include "erhm_defs.vh"

// Overview of operation
// - With integrity mode off, a double error matching a firm-tagged word injects the stored syndrome into the corrector.
// - The injected syndrome stays applied until the corrector reports both errors fixed.
// - With integrity mode off, a double error matching a single hard error record is corrected by injection.
// - With integrity mode on, every detected error is followed by a double complement cycle.
// - A clean double complement result for a double error on a soft-tagged match sets tag 11 and loads the temp syndrome.
// - A double error surviving the double complement on a hard or firm record is unrecoverable.
// - On a two-hard record, a soft double result terminates while a hard result is correctable.
// - On a two-hard record, a temp syndrome unlike the stored one means three or four errors and terminates.
// - A single error on a two-hard record is captured, fixed by double complement and replaces the stored syndrome.
// - Each word has an extra bit marking that more history for it sits in secondary storage.
// - Tag 00 is one soft error, 01 firm; with integrity mode off, a repeat identical single error promotes 00 to 01.
// - Tag 10 is a single hard error and, with integrity mode off, a double error matching it is handled by injection.
module erhm_unit (
    input  wire                  sys_clk,
    input  wire                  rst,
    input  wire                  dc_always,
    input  wire                  err_valid,
    input  wire                  err_single,
    input  wire                  err_double,
    input  wire [`ERHM_AW-1:0]   err_addr,
    input  wire [`ERHM_SW-1:0]   err_syn,
    input  wire                  inj_done,
    input  wire                  dc_done,
    input  wire                  dc_single,
    input  wire                  dc_double,
    input  wire                  sw_wr,
    input  wire [`ERHM_IW-1:0]   sw_idx,
    input  wire [`ERHM_AW-1:0]   sw_addr,
    input  wire [`ERHM_SW-1:0]   sw_syn,
    input  wire [1:0]            sw_tag,
    input  wire                  sw_ext,
    input  wire                  sw_unrec_clr,
    input  wire [`ERHM_IW-1:0]   sw_rd_idx,
    output wire                  inj_en,
    output wire [`ERHM_SW-1:0]   inj_syn,
    output wire                  dc_req,
    output wire                  unrec,
    output wire                  off_req,
    output wire [`ERHM_IW-1:0]   off_idx,
    output wire                  stack_full,
    output wire                  overflow,
    output wire                  busy,
    output wire                  rd_valid,
    output wire [`ERHM_AW-1:0]   rd_addr,
    output wire [`ERHM_SW-1:0]   rd_syn,
    output wire [1:0]            rd_tag,
    output wire                  rd_ext
);

    localparam [2:0] S_IDLE = 3'h0;
    localparam [2:0] S_LOOK = 3'h1;
    localparam [2:0] S_INJ  = 3'h2;
    localparam [2:0] S_DC   = 3'h3;
    localparam [2:0] S_FAIL = 3'h4;

    // Stack storage; contents need no reset, the valid bits gate them
    reg  [`ERHM_AW-1:0]     mem_addr [0:`ERHM_DEPTH-1];
    reg  [`ERHM_SW-1:0]     mem_syn  [0:`ERHM_DEPTH-1];
    reg  [1:0]              mem_tag  [0:`ERHM_DEPTH-1];
    reg  [`ERHM_DEPTH-1:0]  mem_ext;
    reg  [`ERHM_DEPTH-1:0]  valid_q;

    reg  [2:0]              state_q;
    reg  [`ERHM_AW-1:0]     key_q;
    reg  [`ERHM_SW-1:0]     temp_q;
    reg                     dbl_q;
    reg                     inj_en_q;
    reg  [`ERHM_SW-1:0]     inj_syn_q;
    reg                     dc_req_q;
    reg                     unrec_q;
    reg                     off_req_q;
    reg  [`ERHM_IW-1:0]     off_idx_q;
    reg                     overflow_q;
    reg                     rd_valid_q;
    reg  [`ERHM_AW-1:0]     rd_addr_q;
    reg  [`ERHM_SW-1:0]     rd_syn_q;
    reg  [1:0]              rd_tag_q;
    reg                     rd_ext_q;

    // Single write port shared by the sequencer and software
    reg                     we;
    reg  [`ERHM_IW-1:0]     wr_idx;
    reg  [`ERHM_AW-1:0]     wr_addr;
    reg  [`ERHM_SW-1:0]     wr_syn;
    reg  [1:0]              wr_tag;
    reg                     wr_ext;
    reg                     fsm_we;
    reg                     fail;
    reg                     no_room;

    wire [`ERHM_DEPTH*`ERHM_AW-1:0] addr_flat;
    wire                    hit;
    wire [`ERHM_IW-1:0]     m_idx;
    wire [1:0]              m_tag;
    wire [`ERHM_SW-1:0]     m_syn;
    wire [`ERHM_DEPTH-1:0]  soft_vec;
    wire [`ERHM_IW-1:0]     free_idx;
    wire                    free_ok;
    wire                    dc_clean;

    genvar g;

    // Flatten stored addresses and mark words that may be overwritten
    generate
        for (g = 0; g < `ERHM_DEPTH; g = g + 1) begin : g_pack
            assign addr_flat[g*`ERHM_AW +: `ERHM_AW] = mem_addr[g];
            assign soft_vec[g] = ~valid_q[g] | (mem_tag[g] == `ERHM_TAG_SOFT);
        end
    endgenerate

    erhm_match u_match (
        .valid     (valid_q),
        .addr_flat (addr_flat),
        .key       (key_q),
        .hit       (hit),
        .idx       (m_idx)
    );

    assign m_tag    = mem_tag[m_idx];
    assign m_syn    = mem_syn[m_idx];
    assign dc_clean = ~dc_single & ~dc_double;

    // Lowest free or soft-tagged word; hard history is never displaced
    function [`ERHM_IW:0] first_set;
        input [`ERHM_DEPTH-1:0] v;
        integer k;
        begin
            first_set = {1'b0, `ERHM_IDX_RST};
            for (k = `ERHM_DEPTH - 1; k >= 0; k = k - 1) begin
                if (v[k]) begin
                    first_set = {1'b1, k[`ERHM_IW-1:0]};
                end
            end
        end
    endfunction

    assign {free_ok, free_idx} = first_set(soft_vec);

    // Sequencer write decisions, fail detection, then software write
    always @* begin
        fsm_we  = 1'b0;
        fail    = 1'b0;
        no_room = 1'b0;
        wr_idx  = hit ? m_idx : free_idx;
        wr_addr = key_q;
        wr_syn  = hit ? m_syn : temp_q;
        wr_tag  = hit ? m_tag : `ERHM_TAG_SOFT;
        wr_ext  = hit ? mem_ext[m_idx] : 1'b0;
        case (state_q)
            S_LOOK: begin
                if (!dbl_q && !dc_always && !(hit && m_tag == `ERHM_TAG_TWOH)) begin
                    if (!hit) begin
                        fsm_we  = free_ok;
                        no_room = ~free_ok;
                    end else if (m_tag == `ERHM_TAG_SOFT) begin
                        fsm_we = 1'b1;
                        if (m_syn == temp_q) begin
                            wr_tag = `ERHM_TAG_FIRM;
                        end else begin
                            wr_syn = temp_q;
                        end
                    end
                end
            end
            S_DC: begin
                if (dc_done && dbl_q) begin
                    if (dc_double) begin
                        fail = 1'b1;
                    end else if (dc_clean && hit && m_tag == `ERHM_TAG_TWOH) begin
                        fail = (m_syn != temp_q);
                    end else if (dc_clean && (!hit || m_tag == `ERHM_TAG_SOFT)) begin
                        fsm_we  = hit | free_ok;
                        no_room = ~hit & ~free_ok;
                        wr_tag  = `ERHM_TAG_TWOH;
                        wr_syn  = temp_q;
                    end
                end else if (dc_done) begin
                    if (hit && m_tag == `ERHM_TAG_TWOH) begin
                        fsm_we = 1'b1;
                        wr_syn = temp_q;
                        wr_ext = 1'b1;
                    end else if (dc_clean) begin
                        // Clean after complement: the single error is hard
                        fsm_we  = hit | free_ok;
                        no_room = ~hit & ~free_ok;
                        wr_tag  = `ERHM_TAG_HARD;
                        wr_syn  = temp_q;
                    end else if (!hit) begin
                        fsm_we  = free_ok;
                        no_room = ~free_ok;
                    end
                end
            end
            default: begin
                fsm_we = 1'b0;
            end
        endcase
        // Sequencer owns the port; a colliding software write is dropped
        we = fsm_we | (sw_wr & (state_q == S_IDLE));
        if (!fsm_we) begin
            wr_idx  = sw_idx;
            wr_addr = sw_addr;
            wr_syn  = sw_syn;
            wr_tag  = sw_tag;
            wr_ext  = sw_ext;
        end
    end

    // Stack contents
    always @(posedge sys_clk) begin
        if (we) begin
            mem_addr[wr_idx] <= wr_addr;
            mem_syn[wr_idx]  <= wr_syn;
            mem_tag[wr_idx]  <= wr_tag;
        end
    end

    // Valid and extension bits need a known value after reset
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            valid_q <= `ERHM_VLD_RST;
            mem_ext <= `ERHM_VLD_RST;
        end else if (we) begin
            valid_q[wr_idx] <= 1'b1;
            mem_ext[wr_idx] <= wr_ext;
        end
    end

    // Main sequencer: capture, look up, inject or complement, fail
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state_q    <= S_IDLE;
            key_q      <= `ERHM_AD_RST;
            temp_q     <= `ERHM_SYN_RST;
            dbl_q      <= 1'b0;
            inj_en_q   <= 1'b0;
            inj_syn_q  <= `ERHM_SYN_RST;
            dc_req_q   <= 1'b0;
            off_req_q  <= 1'b0;
            off_idx_q  <= `ERHM_IDX_RST;
            overflow_q <= 1'b0;
        end else begin
            dc_req_q  <= 1'b0;
            off_req_q <= 1'b0;
            if (no_room) begin
                overflow_q <= 1'b1;
            end
            case (state_q)
                S_IDLE: begin
                    if (err_valid && (err_single || err_double)) begin
                        key_q   <= err_addr;
                        temp_q  <= err_syn;
                        dbl_q   <= err_double;
                        state_q <= S_LOOK;
                    end
                end
                S_LOOK: begin
                    if (dbl_q && hit && !dc_always &&
                        (m_tag == `ERHM_TAG_FIRM || m_tag == `ERHM_TAG_HARD)) begin
                        inj_en_q  <= 1'b1;
                        inj_syn_q <= m_syn;
                        state_q   <= S_INJ;
                    end else if (dbl_q || dc_always || (hit && m_tag == `ERHM_TAG_TWOH)) begin
                        dc_req_q <= 1'b1;
                        state_q  <= S_DC;
                    end else begin
                        state_q <= S_IDLE;
                    end
                end
                S_INJ: begin
                    // Held through the second decode pass as well
                    if (inj_done) begin
                        inj_en_q <= 1'b0;
                        state_q  <= S_IDLE;
                    end
                end
                S_DC: begin
                    if (dc_done) begin
                        if (fail) begin
                            state_q <= S_FAIL;
                        end else begin
                            state_q <= S_IDLE;
                        end
                        // Offload request for the word, raised at the same edge that overwrites the old syndrome
                        if (!dbl_q && hit && m_tag == `ERHM_TAG_TWOH) begin
                            off_req_q <= 1'b1;
                            off_idx_q <= m_idx;
                        end
                    end
                end
                S_FAIL: begin
                    if (sw_unrec_clr) begin
                        state_q <= S_IDLE;
                    end
                end
                default: begin
                    state_q <= S_IDLE;
                end
            endcase
        end
    end

    // Unrecoverable flag; a new failure beats a same-cycle clear
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            unrec_q <= 1'b0;
        end else begin
            unrec_q <= (fail & dc_done) | (unrec_q & ~sw_unrec_clr);
        end
    end

    // Registered read-back of one stack word
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rd_valid_q <= 1'b0;
            rd_addr_q  <= `ERHM_AD_RST;
            rd_syn_q   <= `ERHM_SYN_RST;
            rd_tag_q   <= `ERHM_TAG_SOFT;
            rd_ext_q   <= 1'b0;
        end else begin
            rd_valid_q <= valid_q[sw_rd_idx];
            rd_addr_q  <= mem_addr[sw_rd_idx];
            rd_syn_q   <= mem_syn[sw_rd_idx];
            rd_tag_q   <= mem_tag[sw_rd_idx];
            rd_ext_q   <= mem_ext[sw_rd_idx];
        end
    end

    reg stack_full_q;
    reg busy_q;

    // Status flags registered so every output leaves a flop
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            stack_full_q <= 1'b0;
            busy_q       <= 1'b0;
        end else begin
            stack_full_q <= &valid_q;
            busy_q       <= (state_q != S_IDLE) | err_valid;
        end
    end

    assign inj_en     = inj_en_q;
    assign inj_syn    = inj_syn_q;
    assign dc_req     = dc_req_q;
    assign unrec      = unrec_q;
    assign off_req    = off_req_q;
    assign off_idx    = off_idx_q;
    assign stack_full = stack_full_q;
    assign overflow   = overflow_q;
    assign busy       = busy_q;
    assign rd_valid   = rd_valid_q;
    assign rd_addr    = rd_addr_q;
    assign rd_syn     = rd_syn_q;
    assign rd_tag     = rd_tag_q;
    assign rd_ext     = rd_ext_q;

endmodule // erhm_unit

//--- test/erhm_corr_model.sv
// Behavioural corrector facing erhm_unit: answers injection and complement.
// Assumes the bench picks the flag outcome and the answer speed.
`timescale 1ns/10ps

module erhm_corr_model (
    input  wire logic sys_clk,
    input  wire logic rst,
    input  wire logic inj_en,
    input  wire logic dc_req,
    input  wire logic slow,
    input  wire logic want_s,
    input  wire logic want_d,
    output logic      inj_done,
    output logic      dc_done,
    output logic      dc_single,
    output logic      dc_double
);
    logic       inj_run_q, dc_run_q;
    logic [3:0] inj_cnt_q, dc_cnt_q;

    // Flags toggle outside dc_done so stale values never look valid
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            {inj_run_q, dc_run_q, inj_done, dc_done, dc_single, dc_double} <= 6'h00;
            {inj_cnt_q, dc_cnt_q} <= 8'h00;
        end else begin
            inj_done <= 1'b0;
            dc_done <= 1'b0;
            dc_single <= ~dc_single;
            dc_double <= ~dc_double;
            if (inj_en && !inj_run_q && !inj_done) begin
                inj_run_q <= 1'b1;
                inj_cnt_q <= slow ? 4'h6 : 4'h1;
            end else if (inj_run_q && inj_cnt_q == 4'h0) begin
                inj_run_q <= 1'b0;
                inj_done <= 1'b1;
            end else if (inj_run_q) begin
                inj_cnt_q <= inj_cnt_q - 4'h1;
            end
            if (dc_req) begin
                dc_run_q <= 1'b1;
                dc_cnt_q <= slow ? 4'h6 : 4'h1;
            end else if (dc_run_q && dc_cnt_q == 4'h0) begin
                dc_run_q <= 1'b0;
                dc_done <= 1'b1;
                dc_single <= want_s;
                dc_double <= want_d;
            end else if (dc_run_q) begin
                dc_cnt_q <= dc_cnt_q - 4'h1;
            end
        end
    end
endmodule // erhm_corr_model

//--- test/erhm_unit_bench.sv
// Self-checking bench for erhm_unit with the corrector model beside it.
// Assumes inputs change at the falling edge; stack is loaded by sw writes.
`timescale 1ns/10ps
`include "erhm_defs.vh"

module erhm_unit_bench;
    logic                sys_clk = 1'b0;
    logic                rst, dc_always, err_valid, err_single, err_double, sw_wr, sw_ext, sw_unrec_clr;
    logic                slow, want_s, want_d;
    logic [`ERHM_AW-1:0] err_addr, sw_addr;
    logic [`ERHM_SW-1:0] err_syn, sw_syn, inj_seen, offload;
    logic [`ERHM_IW-1:0] sw_idx, sw_rd_idx, off_seen;
    logic [1:0]          sw_tag;
    logic                inj_p;
    wire                 inj_done, dc_done, dc_single, dc_double, inj_en, dc_req, unrec, off_req;
    wire                 stack_full, overflow, busy, rd_valid, rd_ext;
    wire [`ERHM_SW-1:0]  inj_syn, rd_syn;
    wire [`ERHM_AW-1:0]  rd_addr;
    wire [`ERHM_IW-1:0]  off_idx;
    wire [1:0]           rd_tag;
    int                  fails = 0, compares = 0, n_inj = 0, n_dc = 0;

    erhm_unit i_dut (.sys_clk(sys_clk), .rst(rst), .dc_always(dc_always), .err_valid(err_valid),
        .err_single(err_single), .err_double(err_double), .err_addr(err_addr), .err_syn(err_syn),
        .inj_done(inj_done), .dc_done(dc_done), .dc_single(dc_single), .dc_double(dc_double),
        .sw_wr(sw_wr), .sw_idx(sw_idx), .sw_addr(sw_addr), .sw_syn(sw_syn), .sw_tag(sw_tag),
        .sw_ext(sw_ext), .sw_unrec_clr(sw_unrec_clr), .sw_rd_idx(sw_rd_idx), .inj_en(inj_en),
        .inj_syn(inj_syn), .dc_req(dc_req), .unrec(unrec), .off_req(off_req), .off_idx(off_idx),
        .stack_full(stack_full), .overflow(overflow), .busy(busy), .rd_valid(rd_valid),
        .rd_addr(rd_addr), .rd_syn(rd_syn), .rd_tag(rd_tag), .rd_ext(rd_ext));
    erhm_corr_model i_corr (.sys_clk(sys_clk), .rst(rst), .inj_en(inj_en), .dc_req(dc_req),
        .slow(slow), .want_s(want_s), .want_d(want_d), .inj_done(inj_done), .dc_done(dc_done),
        .dc_single(dc_single), .dc_double(dc_double));

    // 40 MHz clock
    always #12.5 sys_clk = ~sys_clk;

    // Counts answers of the unit as they happen
    always @(posedge sys_clk) begin
        inj_p <= inj_en;
        if (inj_en && !inj_p) begin
            n_inj <= n_inj + 1;
            inj_seen <= inj_syn;
        end
        if (dc_req)
            n_dc <= n_dc + 1;
        if (off_req)
            off_seen <= off_idx;
    end

    task automatic chk(input string what, input logic [19:0] exp, input logic [19:0] got);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [3:0] i, input logic [7:0] a, input logic [7:0] s, input logic [1:0] t);
        @(negedge sys_clk);
        {sw_wr, sw_idx, sw_addr, sw_syn, sw_tag, sw_ext} = {1'b1, i, a, s, t, 1'b0};
        @(negedge sys_clk);
        sw_wr = 1'b0;
    endtask

    // Word read back one cycle late; allow settling
    task automatic rd(input logic [3:0] i, input logic [7:0] a, input logic [7:0] s, input logic [1:0] t,
                      input logic e);
        @(negedge sys_clk);
        sw_rd_idx = i;
        repeat (3) @(negedge sys_clk);
        chk("stack word", {a, s, t, e, 1'b1}, {rd_addr, rd_syn, rd_tag, rd_ext, rd_valid});
    endtask

    // One error event; expects injection, complement and failure outcome
    task automatic ev(input logic d, input logic [7:0] a, input logic [7:0] s, input logic fs, input logic fd,
                      input logic ei, input logic ed, input logic eu);
        int i0, d0, n;
        i0 = n_inj;
        d0 = n_dc;
        n = 0;
        {want_s, want_d} = {fs, fd};
        @(negedge sys_clk);
        {err_valid, err_single, err_double, err_addr, err_syn} = {1'b1, !d, d, a, s};
        @(negedge sys_clk);
        err_valid = 1'b0;
        while (busy && !unrec && n < 300) begin
            @(negedge sys_clk);
            n++;
        end
        // A sequencer that never settles is a failure in its own right
        if (n == 300) begin
            fails++;
        end
        repeat (3) @(negedge sys_clk);
        chk("inj dc unrec", {17'h0, ei, ed, eu}, {17'h0, n_inj != i0, n_dc != d0, unrec});
    endtask

    task automatic clr();
        @(negedge sys_clk);
        sw_unrec_clr = 1'b1;
        @(negedge sys_clk);
        sw_unrec_clr = 1'b0;
        repeat (3) @(negedge sys_clk);
        chk("unrec", 20'h0_0000, {19'h0, unrec});
    endtask

    task automatic results();
        if (fails == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // Watchdog well beyond the few hundred cycles of the tests
    initial begin
        repeat (20000) @(posedge sys_clk);
        fails++;
        results();
    end

    initial begin
        rst = 1'b1;
        {dc_always, err_valid, err_single, err_double, sw_wr, sw_ext, sw_unrec_clr} = 7'h00;
        {slow, want_s, want_d, err_addr, err_syn, sw_addr, sw_syn, sw_idx, sw_rd_idx, sw_tag} = 0;
        repeat (20) @(negedge sys_clk);
        rst = 1'b0;
        chk("reset outputs", 20'h0_0000, {12'h000, inj_en, dc_req, unrec, off_req, stack_full, overflow,
            busy, rd_valid});
        wr(4'h0, 8'h10, 8'h5A, 2'h1);
        wr(4'h1, 8'h20, 8'h6B, 2'h2);
        wr(4'h2, 8'h30, 8'h33, 2'h3);
        wr(4'h3, 8'h40, 8'h11, 2'h0);
        rd(4'h0, 8'h10, 8'h5A, 2'h1, 1'b0);
        rd(4'h1, 8'h20, 8'h6B, 2'h2, 1'b0);
        rd(4'h2, 8'h30, 8'h33, 2'h3, 1'b0);
        rd(4'h3, 8'h40, 8'h11, 2'h0, 1'b0);
        slow = 1'b1;
        ev(1'b1, 8'h10, 8'h0F, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
        chk("inj_syn firm", {12'h000, 8'h5A}, {12'h000, inj_seen});
        slow = 1'b0;
        ev(1'b1, 8'h20, 8'h0E, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
        chk("inj_syn hard", {12'h000, 8'h6B}, {12'h000, inj_seen});
        ev(1'b0, 8'h40, 8'h11, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
        rd(4'h3, 8'h40, 8'h11, 2'h1, 1'b0);
        ev(1'b0, 8'h50, 8'h22, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
        rd(4'h4, 8'h50, 8'h22, 2'h0, 1'b0);
        ev(1'b1, 8'h50, 8'h77, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
        rd(4'h4, 8'h50, 8'h77, 2'h3, 1'b0);
        ev(1'b0, 8'h30, 8'h44, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0);
        rd(4'h2, 8'h30, 8'h44, 2'h3, 1'b1);
        chk("off_idx", 20'h0_0002, {16'h0000, off_seen});
        offload = 8'h33 ^ rd_syn;
        chk("offload", 20'h0_0077, {12'h000, offload});
        ev(1'b1, 8'h30, 8'h44, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
        ev(1'b1, 8'h30, 8'h55, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1);
        clr();
        ev(1'b1, 8'h30, 8'h44, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1);
        clr();
        dc_always = 1'b1;
        ev(1'b1, 8'h10, 8'h0F, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1);
        clr();
        ev(1'b0, 8'h10, 8'h5A, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
        rd(4'h0, 8'h10, 8'h5A, 2'h2, 1'b0);
        // Fill the rest with hard history so no word may be displaced
        for (int j = 5; j < 16; j++) begin
            wr(j[3:0], 8'h80 | j[7:0], 8'h01, 2'h2);
        end
        ev(1'b0, 8'hF0, 8'h09, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
        chk("full overflow", 20'h0_0003, {18'h0_0000, stack_full, overflow});
        results();
    end
endmodule // erhm_unit_bench

//--- test/erhm_unit_sva.sv
// Checker for erhm_unit: corrector handshake and failure flag.
// Assumes only the ports of erhm_unit, one clock, reset rst.
`timescale 1ns/10ps

module erhm_unit_sva (
    input wire logic       sys_clk,
    input wire logic       rst,
    input wire logic       dc_always,
    input wire logic       err_valid,
    input wire logic       err_single,
    input wire logic       err_double,
    input wire logic       inj_done,
    input wire logic       dc_done,
    input wire logic       dc_double,
    input wire logic       sw_unrec_clr,
    input wire logic       inj_en,
    input wire logic [7:0] inj_syn,
    input wire logic       dc_req,
    input wire logic       unrec,
    input wire logic       off_req,
    input wire logic       busy
);
    logic busy_p_q, ev_p_q, dbl_q;
    wire  take = err_valid && (err_single || err_double) && !busy && !busy_p_q && !ev_p_q;

    // History, so a refused event never counts as taken
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            {busy_p_q, ev_p_q, dbl_q} <= 3'h0;
        end else begin
            busy_p_q <= busy;
            ev_p_q <= err_valid;
            if (take)
                dbl_q <= err_double;
        end
    end

    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);

    inj_hold_a: assert property (inj_en && !inj_done |=> inj_en) else $error("injection dropped early");
    inj_end_a: assert property (inj_en && inj_done |=> !inj_en) else $error("injection held too long");
    inj_syn_a: assert property (inj_en && $past(inj_en) |-> $stable(inj_syn)) else $error("syndrome moved");
    dbl_route_a: assert property (take && err_double && !dc_always |-> ##[1:3] (inj_en || dc_req))
        else $error("double error not acted on");
    dc_every_a: assert property (take && dc_always |-> ##[1:3] dc_req) else $error("no complement request");
    dc_pulse_a: assert property (dc_req |=> !dc_req) else $error("complement request too long");
    dbl_fail_a: assert property (dc_done && dc_double && dbl_q && busy |=> unrec)
        else $error("surviving double error not fatal");
    unrec_hold_a: assert property (unrec && !sw_unrec_clr |=> unrec) else $error("failure flag lost");
    off_pulse_a: assert property (off_req |=> !off_req) else $error("offload request too long");
    take_busy_a: assert property (take |=> busy) else $error("event taken without busy");

    inj_c: cover property ($rose(inj_en));
    dc_c: cover property (dc_req);
    off_c: cover property (off_req);
    unrec_c: cover property ($rose(unrec));
endmodule // erhm_unit_sva

bind erhm_unit erhm_unit_sva i_sva (.sys_clk(sys_clk), .rst(rst), .dc_always(dc_always),
    .err_valid(err_valid), .err_single(err_single), .err_double(err_double), .inj_done(inj_done),
    .dc_done(dc_done), .dc_double(dc_double), .sw_unrec_clr(sw_unrec_clr), .inj_en(inj_en),
    .inj_syn(inj_syn), .dc_req(dc_req), .unrec(unrec), .off_req(off_req), .busy(busy));
